// File: core/dir_buf_ctrl_defs.svh
`ifndef DIR_BUF_CTRL_DEFS_SVH
`define DIR_BUF_CTRL_DEFS_SVH

// lane count of the buffer
`define LANE_COUNT       2
// worst enable time after a direction switch, in ns
`define ENABLE_TIME_NS   13
`define CLK_PERIOD_NS    10
// least time rounds up to whole cycles
`define ENABLE_CYCLES    ((`ENABLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// idle cycles with both sides released before the switch
`define IDLE_CYCLES      2
`define CNT_W            4

`endif

// File: core/dir_buf_ctrl_pkg.sv
package dir_buf_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_A_SEND,
    ST_A_RELEASE,
    ST_SWITCH,
    ST_SETTLE,
    ST_B_SEND
  } phase_e;
  typedef logic [1:0] lane_t;
endpackage : dir_buf_ctrl_pkg

// File: core/dir_buf_ctrl.sv
`timescale 1ns/1ps
`include "dir_buf_ctrl_defs.svh"

module dir_buf_ctrl
  import dir_buf_ctrl_pkg::*;
#(
  parameter int ENABLE_CYCLES = `ENABLE_CYCLES,
  parameter int IDLE_CYCLES   = `IDLE_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  input  wire logic                      req_a_to_b,
  input  wire logic                      req_b_to_a,
  input  wire dir_buf_ctrl_pkg::lane_t   a_tx_data,
  input  wire dir_buf_ctrl_pkg::lane_t   b_tx_data,
  input  wire dir_buf_ctrl_pkg::lane_t   a_lane_in,
  input  wire dir_buf_ctrl_pkg::lane_t   b_lane_in,
  output logic                           dir_out,
  output dir_buf_ctrl_pkg::lane_t        a_lane_out,
  output logic                           a_lane_oe,
  output dir_buf_ctrl_pkg::lane_t        b_lane_out,
  output logic                           b_lane_oe,
  output logic                           a_pull_up,
  output logic                           b_pull_up,
  output logic                           rx_valid,
  output dir_buf_ctrl_pkg::lane_t        rx_data,
  output logic                           busy
);
  import dir_buf_ctrl_pkg::*;

  logic                rst_s1_q;
  logic                rst_s2_q;
  phase_e              phase_q;
  logic                target_b_q;
  logic [`CNT_W-1:0]   cnt_q;
  logic [`CNT_W-1:0]   valid_cnt_q;

  // reset release through two flops, async assert
  // the rest of the block sees only the synchronised copy, so the release
  // never lands in the middle of a clock edge for the phase machine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // five-phase sequence
  // a reversal always passes both idle phases, never a direct swap
  // requests are looked at only in a send phase; a level held through a
  // reversal cannot start a second one, at the cost of one lost request
  always_ff @(posedge clk_sys or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      phase_q    <= ST_A_RELEASE;
      target_b_q <= 1'b0;
      cnt_q      <= '0;
    end else if (clk_en) begin
      unique case (phase_q)
        ST_A_SEND: begin
          if (req_b_to_a) begin
            phase_q    <= ST_A_RELEASE;
            target_b_q <= 1'b1;
            cnt_q      <= '0;
          end
        end
        ST_B_SEND: begin
          if (req_a_to_b) begin
            phase_q    <= ST_A_RELEASE;
            target_b_q <= 1'b0;
            cnt_q      <= '0;
          end
        end
        ST_A_RELEASE: begin
          if (cnt_q >= IDLE_CYCLES[`CNT_W-1:0] - 1'b1) begin
            phase_q <= ST_SWITCH;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_SWITCH: begin
          phase_q <= ST_SETTLE;
          cnt_q   <= '0;
        end
        ST_SETTLE: begin
          // wait till old port is disabled
          if (cnt_q >= ENABLE_CYCLES[`CNT_W-1:0] - 1'b1) begin
            phase_q <= target_b_q ? ST_B_SEND : ST_A_SEND;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // direction pin and drivers, registered
  // A side only drives in ST_A_SEND with dir high, B only in ST_B_SEND with dir low
  always_ff @(posedge clk_sys or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      dir_out    <= 1'b1;
      a_lane_oe  <= 1'b0;
      b_lane_oe  <= 1'b0;
      a_lane_out <= '0;
      b_lane_out <= '0;
      busy       <= 1'b1;
    end else if (clk_en) begin
      if (phase_q == ST_SWITCH)
        dir_out <= ~target_b_q;
      a_lane_oe  <= (phase_q == ST_A_SEND) && !req_b_to_a;
      b_lane_oe  <= (phase_q == ST_B_SEND) && !req_a_to_b;
      a_lane_out <= a_tx_data;
      b_lane_out <= b_tx_data;
      busy       <= !(phase_q == ST_A_SEND || phase_q == ST_B_SEND);
    end
  end

  // same idle bias on both sides
  // bias is weak keeper only, no board resistor assumed
  always_ff @(posedge clk_sys or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      a_pull_up <= 1'b1;
      b_pull_up <= 1'b1;
    end else if (clk_en) begin
      a_pull_up <= 1'b1;
      b_pull_up <= 1'b1;
    end
  end

  // receive data valid after enable time
  // the count restarts whenever both drivers are off, so stale data from
  // the previous direction is never flagged valid
  always_ff @(posedge clk_sys or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      valid_cnt_q <= '0;
      rx_valid    <= 1'b0;
      rx_data     <= '0;
    end else if (clk_en) begin
      if (!a_lane_oe && !b_lane_oe) begin
        valid_cnt_q <= '0;
        rx_valid    <= 1'b0;
      end else if (valid_cnt_q < ENABLE_CYCLES[`CNT_W-1:0]) begin
        valid_cnt_q <= valid_cnt_q + 1'b1;
        rx_valid    <= 1'b0;
      end else begin
        rx_valid <= 1'b1;
      end
      rx_data <= a_lane_oe ? b_lane_in : a_lane_in;
    end
  end

  a_no_contention: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    !(a_lane_oe && b_lane_oe)) else $error("both sides drive at once");
  // A side drives only with direction high
  a_a_dir_high: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    a_lane_oe |-> dir_out) else $error("A side drives with direction low");
  a_b_dir_low: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    b_lane_oe |-> !dir_out) else $error("B side drives with direction high");
  // no driving right after a direction change
  a_dir_quiet: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    (clk_en && $changed(dir_out)) |-> !a_lane_oe && !b_lane_oe)
    else $error("driver active at direction change");
  a_valid_delay: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    ($rose(a_lane_oe) || $rose(b_lane_oe)) |-> !rx_valid)
    else $error("valid before enable time");
  a_same_bias: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    a_pull_up == b_pull_up) else $error("idle bias differs");

  // bias stays at the chosen pull-up level
  a_bias_up: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    a_pull_up && b_pull_up)
    else $error("idle bias not pulled up");

  // both drivers off while a reversal runs
  a_busy_quiet: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    busy |-> !a_lane_oe && !b_lane_oe)
    else $error("driver active while switching");

  // direction moves only inside a reversal
  a_dir_in_busy: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    $changed(dir_out) |-> busy)
    else $error("direction changed outside a reversal");

  // old port left quiet for the enable time
  a_enable_gap: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    $changed(dir_out) |-> ##1 (!a_lane_oe && !b_lane_oe)[*2])
    else $error("driver enabled inside enable time");

  // valid only once a driver has stood for a while
  a_rx_after_oe: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    $rose(rx_valid) |-> $past(a_lane_oe || b_lane_oe, 2))
    else $error("valid without a standing driver");

  // a low clock enable freezes the whole sequence
  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (!rst_s2_q)
    !clk_en |=> $stable(dir_out) && $stable(a_lane_oe) && $stable(b_lane_oe) && $stable(busy))
    else $error("outputs moved while frozen");

endmodule : dir_buf_ctrl

// File: tb/buffer_model.sv
`timescale 1ns/1ps
module buffer_model
  import dir_buf_ctrl_pkg::*;
(
  input  wire logic                    dir,
  input  wire logic                    sup_a,
  input  wire logic                    sup_b,
  input  wire dir_buf_ctrl_pkg::lane_t a_sys,
  input  wire logic                    a_sys_oe,
  input  wire dir_buf_ctrl_pkg::lane_t b_sys,
  input  wire logic                    b_sys_oe,
  output dir_buf_ctrl_pkg::lane_t      a_bus,
  output dir_buf_ctrl_pkg::lane_t      b_bus,
  output logic                         clash
);
  logic pwr;
  assign pwr = sup_a & sup_b;
  always @* begin
    if (a_sys_oe) a_bus = a_sys;
    if (b_sys_oe) b_bus = b_sys;
    if (pwr && !dir) a_bus = b_bus;
    if (pwr && dir) b_bus = a_bus;
  end
  // two drivers on one line
  assign clash = (a_sys_oe & pwr & ~dir) | (b_sys_oe & pwr & dir);
endmodule : buffer_model

// File: tb/dir_buf_ctrl_tb.sv
`timescale 1ns/1ps
module dir_buf_ctrl_tb;
  import dir_buf_ctrl_pkg::*;
  logic  clk_sys, rst_n, req_a_to_b, req_b_to_a, dir_out, a_lane_oe, b_lane_oe;
  logic  a_pull_up, b_pull_up, rx_valid, busy, clash, clk_en;
  lane_t a_tx_data, b_tx_data, a_bus, b_bus, a_lane_out, b_lane_out, rx_data;
  int    n_fail, tests_run;
  dir_buf_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req_a_to_b(req_a_to_b),
    .req_b_to_a(req_b_to_a), .a_tx_data(a_tx_data), .b_tx_data(b_tx_data), .a_lane_in(a_bus),
    .b_lane_in(b_bus), .dir_out(dir_out), .a_lane_out(a_lane_out), .a_lane_oe(a_lane_oe),
    .b_lane_out(b_lane_out), .b_lane_oe(b_lane_oe), .a_pull_up(a_pull_up), .b_pull_up(b_pull_up),
    .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy));
  buffer_model partner (.dir(dir_out), .sup_a(1'b1), .sup_b(1'b1), .a_sys(a_lane_out),
    .a_sys_oe(a_lane_oe), .b_sys(b_lane_out), .b_sys_oe(b_lane_oe), .a_bus(a_bus), .b_bus(b_bus),
    .clash(clash));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input lane_t exp, input lane_t got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // bounded wait on busy (sel 0) or rx_valid (sel 1), sampled mid-cycle
  task automatic wait_until(input bit sel, input logic want);
    int i;
    for (i = 0; i < 40 && (sel ? rx_valid : busy) !== want; i++) @(negedge clk_sys);
    if (i == 40) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_until
  // contention and bias watched every cycle
  always @(negedge clk_sys) begin
    chk("clash", 2'h0, {1'b0, clash});
    chk("bias a", 2'h1, {1'b0, a_pull_up});
    chk("bias b", 2'h1, {1'b0, b_pull_up});
  end
  // two patterns cover each lane alone, no inversion
  task automatic send(input logic to_b);
    for (int p = 1; p < 3; p++) begin
      @(posedge clk_sys);
      if (to_b) a_tx_data <= lane_t'(p);
      else b_tx_data <= lane_t'(p);
      wait_until(1, 1);
      repeat (3) @(negedge clk_sys);
      chk("lane", lane_t'(p), to_b ? b_bus : a_bus);
      chk("rx", lane_t'(p), rx_data);
    end
    $display("send done");
  endtask : send
  task automatic reverse(input logic to_b);
    @(posedge clk_sys);
    if (to_b) req_a_to_b <= 1'b1;
    else req_b_to_a <= 1'b1;
    wait_until(0, 1);
    @(posedge clk_sys);
    req_a_to_b <= 1'b0;
    req_b_to_a <= 1'b0;
    @(negedge clk_sys);
    chk("idle oe", 2'h0, {a_lane_oe, b_lane_oe});
    wait_until(0, 0);
    chk("dir", {1'b0, to_b}, {1'b0, dir_out});
    chk("oe", to_b ? 2'h2 : 2'h1, {a_lane_oe, b_lane_oe});
    $display("reverse done");
  endtask : reverse
  // clock enable low in mid-reversal holds direction and busy
  task automatic freeze_switch;
    @(posedge clk_sys);
    req_b_to_a <= 1'b1;
    wait_until(0, 1);
    @(posedge clk_sys);
    req_b_to_a <= 1'b0;
    clk_en     <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("frozen dir", 2'h1, {1'b0, dir_out});
    chk("frozen busy", 2'h1, {1'b0, busy});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    wait_until(0, 0);
    chk("dir", 2'h0, {1'b0, dir_out});
    chk("oe", 2'h1, {a_lane_oe, b_lane_oe});
    $display("freeze done");
  endtask : freeze_switch
  // reset in mid-run from B sending back to A sending
  task automatic reset_mid;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("reset dir", 2'h1, {1'b0, dir_out});
    chk("reset oe", 2'h0, {a_lane_oe, b_lane_oe});
    chk("reset busy", 2'h1, {1'b0, busy});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_until(0, 0);
    chk("dir", 2'h1, {1'b0, dir_out});
    chk("oe", 2'h2, {a_lane_oe, b_lane_oe});
    $display("reset done");
  endtask : reset_mid
  initial begin
    rst_n = 0;
    clk_en = 1;
    {req_a_to_b, req_b_to_a, a_tx_data, b_tx_data} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_until(0, 0);
    send(1'b1);
    // same-direction request must be ignored
    @(posedge clk_sys);
    req_a_to_b <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("busy", 2'h0, {1'b0, busy});
    @(posedge clk_sys);
    req_a_to_b <= 1'b0;
    $display("same direction done");
    reverse(1'b0);
    send(1'b0);
    reverse(1'b1);
    send(1'b1);
    freeze_switch();
    reset_mid();
    tally_and_finish();
  end
endmodule : dir_buf_ctrl_tb
